// >>> pwrc_core.sv
// Purpose: idle and stop power modes of the processor core
// Assumes: classic Wishbone slave, 32-bit data, one clock clk_i at 50 MHz
// Notes: core clock gating, oscillator run and reset sequencing come from here
// ----------------------------------------------------------------
// How it works
// [R1] idle gates the core clock only; peripheral clock and oscillator keep running
// [R2] stop gates core, peripherals and oscillator; only the clock detector stays alive
// [R3] idle select write enters idle when the writing instruction completes
// [R4] idle holds state: core clock gated, no register changes by this block
// [R5] idle ends on an enabled interrupt or on the external reset pin
// [R6] interrupt wake clears the idle select bit and restarts the core clock
// [R7] core services the interrupt then returns after the idle-setting instruction
// [R8] reset ending idle runs reset sequence, fetch restarts at address zero
// [R9] software follows the idle write with an instruction of two bytes or more
// [R10] enabled watchdog keeps counting in idle and resets the device on timeout
// [R11] stop select write enters stop when the writing instruction completes
// [R12] software shuts analog peripherals down before setting stop select
// [R13] stop ends only by internal or external reset, then reset sequence
// [R14] enabled missing clock detector resets out of stop after its timeout
// [R15] idle and stop select bits always read back as zero
// [R16] five general flags are free read/write storage with no effect
// [R17] idle and stop set together are taken as a stop request
// ----------------------------------------------------------------
//
// The Wishbone register port was chosen for this implementation.
`include "pwrc_regs.svh"

module pwrc_core
   import pwrc_pkg::*;
#(
   parameter int MCD_CYCLES = `PWRC_MCD_CYCLES,
   parameter int WDT_CYCLES = `PWRC_WDT_CYCLES,
   parameter int RST_CYCLES = `PWRC_RST_SEQ_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // core side
   input wire logic instr_done_i,
   input wire logic irq_i,
   // pins
   input wire logic rst_pin_n_i,
   input wire logic osc_tick_i,
   // clock and reset controls
   output pwrc_ctl_t ctl_o,
   output logic [15:0] reset_addr_o
);

   // refused at elaboration: the sequence counter is only eight bits wide
   if (RST_CYCLES < 1 || RST_CYCLES > 255) begin
      $error("pwrc_core: RST_CYCLES out of range 1..255");
   end

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   pwrc_mode_t mode_r;
   pwrc_pctl_t pctl_r;
   logic idle_req_r;
   logic stop_req_r;
   logic wdt_en_r;
   logic mcd_en_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic [7:0] seq_r;
   logic [1:0] cause_r;
   logic pin_s1_r;
   logic pin_s2_r;
   logic osc_s1_r;
   logic osc_s2_r;
   logic osc_s3_r;
   logic wb_hit;
   logic wb_wr;
   logic [9:0] wb_idx;
   logic pin_rst;
   logic wdt_kick;
   logic wdt_exp;
   logic mcd_exp;
   logic int_rst;

   function automatic logic idx_is(input logic [9:0] idx, input logic [9:0] want);
      idx_is = (idx == want);
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // reset pin and oscillator tick come from outside the clock domain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
      end else begin
         pin_s1_r <= rst_pin_n_i;
         pin_s2_r <= pin_s1_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_s3_r <= 1'b0;
      end else begin
         osc_s1_r <= osc_tick_i;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
      end
   end

   assign pin_rst = !pin_s2_r;

   // ----------------------------------------------------------------
   // wishbone decode
   // ----------------------------------------------------------------
   // one word per register; the word index sits above the byte lanes
   assign wb_idx = adr_i[11:2];
   assign wb_hit = cyc_i && stb_i && !ack_r;
   assign wb_wr = wb_hit && we_i && sel_i[0];
   assign wdt_kick = wb_wr && idx_is(wb_idx, `PWRC_IDX_SAFETY) && dat_i[`PWRC_BIT_WDT_KICK];

   // ack one cycle after the strobe, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_hit;
      end
   end

   // read data; unmapped words answer zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= '0;
      end else if (wb_hit && !we_i) begin
         dat_r <= '0;
         if (idx_is(wb_idx, `PWRC_IDX_POWER_CONTROL)) begin
            dat_r[`PWRC_FLAGS_MSB:`PWRC_FLAGS_LSB] <= pctl_r.general_flag; // R16
            dat_r[`PWRC_BIT_STOP] <= 1'b0; // R15
            dat_r[`PWRC_BIT_IDLE] <= 1'b0; // R15
         end else if (idx_is(wb_idx, `PWRC_IDX_STATUS)) begin
            dat_r[1:0] <= mode_r;
            dat_r[2] <= idle_req_r;
            dat_r[3] <= stop_req_r;
            dat_r[5:4] <= cause_r;
         end else if (idx_is(wb_idx, `PWRC_IDX_SAFETY)) begin
            dat_r[`PWRC_BIT_WDT_EN] <= wdt_en_r;
            dat_r[`PWRC_BIT_MCD_EN] <= mcd_en_r;
         end
      end
   end

   assign dat_o = dat_r;
   assign ack_o = ack_r;

   // ----------------------------------------------------------------
   // reset sources
   // ----------------------------------------------------------------
   // watchdog is a timer, so it sleeps in stop
   pwrc_timeout #(
      .CYCLES(WDT_CYCLES)
   ) u_wdt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(wdt_en_r && mode_r != PWRC_STOP && mode_r != PWRC_RSEQ), // R10 R2
      .clear_i(wdt_kick),
      .expire_o(wdt_exp)
   );

   // detector restarts on every oscillator edge; no edges in stop
   pwrc_timeout #(
      .CYCLES(MCD_CYCLES)
   ) u_mcd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(mcd_en_r && mode_r != PWRC_RSEQ), // R14 R2
      .clear_i(osc_s2_r != osc_s3_r),
      .expire_o(mcd_exp)
   );

   assign int_rst = pin_rst || wdt_exp || mcd_exp; // R5 R13

   // last reset cause: 1 pin, 2 watchdog, 3 clock detector
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_r <= 2'h0;
      end else if (pin_rst) begin
         cause_r <= 2'h1;
      end else if (wdt_exp) begin
         cause_r <= 2'h2;
      end else if (mcd_exp) begin
         cause_r <= 2'h3;
      end
   end

   // ----------------------------------------------------------------
   // power control and safety registers
   // ----------------------------------------------------------------
   // the device reset clears everything the reset sequence would
   always_ff @(posedge clk_i) begin
      if (rst_i || int_rst) begin
         pctl_r <= `PWRC_POWER_CONTROL_RST;
      end else if (wb_wr && idx_is(wb_idx, `PWRC_IDX_POWER_CONTROL)) begin
         pctl_r.general_flag <= dat_i[`PWRC_FLAGS_MSB:`PWRC_FLAGS_LSB]; // R16
      end
   end

   // enables survive internal resets so the detector stays armed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdt_en_r <= 1'b0;
         mcd_en_r <= 1'b0;
      end else if (wb_wr && idx_is(wb_idx, `PWRC_IDX_SAFETY)) begin
         wdt_en_r <= dat_i[`PWRC_BIT_WDT_EN];
         mcd_en_r <= dat_i[`PWRC_BIT_MCD_EN];
      end
   end

   // mode requests wait for the writing instruction to complete
   always_ff @(posedge clk_i) begin
      if (rst_i || int_rst) begin
         idle_req_r <= 1'b0;
         stop_req_r <= 1'b0;
      end else if (wb_wr && idx_is(wb_idx, `PWRC_IDX_POWER_CONTROL)) begin
         stop_req_r <= dat_i[`PWRC_BIT_STOP]; // R17
         idle_req_r <= dat_i[`PWRC_BIT_IDLE] && !dat_i[`PWRC_BIT_STOP]; // R17
      end else if (mode_r == PWRC_IDLE && irq_i) begin
         idle_req_r <= 1'b0; // R6
      end else if (instr_done_i && mode_r == PWRC_RUN) begin
         stop_req_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // mode sequencer
   // ----------------------------------------------------------------
   // any reset wins over every other transition
   always_ff @(posedge clk_i) begin
      if (rst_i || int_rst) begin
         mode_r <= PWRC_RSEQ; // R8 R13
      end else begin
         case (mode_r)
            PWRC_RUN: begin
               if (instr_done_i && stop_req_r) begin
                  mode_r <= PWRC_STOP; // R11
               end else if (instr_done_i && idle_req_r) begin
                  mode_r <= PWRC_IDLE; // R3
               end
            end
            PWRC_IDLE: begin
               // core resumes and takes the pending interrupt first
               if (irq_i) begin
                  mode_r <= PWRC_RUN; // R5 R7
               end
            end
            PWRC_STOP: begin
               mode_r <= PWRC_STOP; // R13
            end
            PWRC_RSEQ: begin
               if (seq_r == 8'(RST_CYCLES - 1)) begin
                  mode_r <= PWRC_RUN;
               end
            end
            default: begin
               mode_r <= PWRC_RSEQ;
            end
         endcase
      end
   end

   // reset sequence length counter
   always_ff @(posedge clk_i) begin
      if (rst_i || int_rst || mode_r != PWRC_RSEQ) begin
         seq_r <= 8'h00;
      end else begin
         seq_r <= seq_r + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // clock and reset controls
   // ----------------------------------------------------------------
   // gating only: core state is frozen, not cleared, while idle
   always_comb begin
      ctl_o.cpu_clk_en = (mode_r == PWRC_RUN); // R1 R4
      ctl_o.periph_clk_en = (mode_r != PWRC_STOP); // R1 R2
      ctl_o.osc_run = (mode_r != PWRC_STOP); // R2 R11
      ctl_o.cpu_rst = (mode_r == PWRC_RSEQ); // R8
   end

   // fetch address after the reset sequence
   always_ff @(posedge clk_i) begin
      reset_addr_o <= `PWRC_RESET_ADDR; // R8
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_idle_entry: assert property ( // R3
      mode_r == PWRC_RUN && instr_done_i && idle_req_r && !stop_req_r && !int_rst
      |=> mode_r == PWRC_IDLE && !ctl_o.cpu_clk_en && ctl_o.periph_clk_en)
      else $error("idle not entered after instruction completed");
   a_stop_entry: assert property ( // R11
      mode_r == PWRC_RUN && instr_done_i && stop_req_r && !int_rst
      |=> mode_r == PWRC_STOP && !ctl_o.osc_run && !ctl_o.periph_clk_en)
      else $error("stop not entered after instruction completed");
   a_idle_wake: assert property ( // R6
      mode_r == PWRC_IDLE && irq_i && !int_rst
      |=> mode_r == PWRC_RUN && !idle_req_r && ctl_o.cpu_clk_en)
      else $error("interrupt did not wake from idle");
   a_stop_hold: assert property ( // R13
      mode_r == PWRC_STOP && !int_rst |=> mode_r == PWRC_STOP)
      else $error("stop left without a reset");
   a_reset_seq: assert property ( // R8
      int_rst |=> ctl_o.cpu_rst [*2] ##0 (reset_addr_o == 16'h0000))
      else $error("reset did not start the reset sequence");
   a_pin_wake: assert property ( // R5
      mode_r == PWRC_IDLE && !rst_pin_n_i ##1 !rst_pin_n_i |=> ##1 mode_r == PWRC_RSEQ)
      else $error("reset pin did not end idle");
   a_sel_reads0: assert property ( // R15
      ack_r && $past(!we_i && idx_is(wb_idx, `PWRC_IDX_POWER_CONTROL)) |-> dat_o[1:0] == 2'b00)
      else $error("mode select bits read nonzero");
   a_flag_store: assert property ( // R16
      wb_wr && idx_is(wb_idx, `PWRC_IDX_POWER_CONTROL) && !int_rst
      |=> pctl_r.general_flag == $past(dat_i[6:2]))
      else $error("general flags not stored");
   a_both_stop: assert property ( // R17
      wb_wr && idx_is(wb_idx, `PWRC_IDX_POWER_CONTROL) && dat_i[1] && dat_i[0] && !int_rst
      |=> stop_req_r && !idle_req_r)
      else $error("idle plus stop not taken as stop");
   a_wdt_idle: assert property ( // R10
      wdt_exp && mode_r == PWRC_IDLE |=> mode_r == PWRC_RSEQ)
      else $error("watchdog did not end idle");
   a_mcd_stop: assert property ( // R14
      mcd_exp && mode_r == PWRC_STOP |=> mode_r == PWRC_RSEQ)
      else $error("clock detector did not end stop");
   a_ack_pulse: assert property (
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   c_idle_round: cover property (mode_r == PWRC_IDLE ##1 mode_r == PWRC_RUN);
   c_stop_reset: cover property (mode_r == PWRC_STOP ##1 mode_r == PWRC_RSEQ);
   c_wdt_fire: cover property (wdt_exp && mode_r == PWRC_IDLE);
   c_both_bits: cover property (wb_wr && dat_i[1:0] == 2'b11);

endmodule

// >>> pwrc_core_tb.sv
// Purpose: self-checking bench of the idle and stop power modes
// Assumes: classic Wishbone master, one 50 MHz clock, sync reset
// Notes: watchdog and detector counts shortened to keep the run brief
`include "pwrc_regs.svh"
`define TB_CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end

module pwrc_core_tb
   import pwrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------
   // constants and signals
   // ----------------------------------------------------------------
   localparam int WDT_N = 64;
   localparam int MCD_N = 40;
   localparam int RST_N = 16;
   localparam logic [11:0] A_PCTL = {`PWRC_IDX_POWER_CONTROL, 2'b00};
   localparam logic [11:0] A_STAT = {`PWRC_IDX_STATUS, 2'b00};
   localparam logic [11:0] A_SAFE = {`PWRC_IDX_SAFETY, 2'b00};
   localparam logic [11:0] A_NONE = 12'hFFC;
   localparam pwrc_ctl_t C_RUN = 4'hE;
   localparam pwrc_ctl_t C_IDLE = 4'h6;
   localparam pwrc_ctl_t C_STOP = 4'h0;
   localparam pwrc_ctl_t C_RSEQ = 4'h7;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [11:0] adr_i = 12'h000;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic instr_done_i = 1'b0;
   logic irq_i = 1'b0;
   logic rst_pin_n_i = 1'b1;
   logic osc_tick_i = 1'b0;
   logic [31:0] dat_o;
   logic ack_o;
   pwrc_ctl_t ctl_o;
   logic [15:0] reset_addr_o;
   int error_cnt = 0;
   int num_checks = 0;
   int model_flags = 0;
   int cause_q[$];
   int n;
   logic [7:0] q;
   logic [7:0] d;
   logic [1:0] osc_div = 2'h0;

   // 20 ns clock
   always #10 clk_i = ~clk_i;

   // oscillator pin toggles only while the design keeps it running
   always @(posedge clk_i) begin
      osc_div <= osc_div + 2'h1;
      if (ctl_o.osc_run === 1'b1 && osc_div == 2'h3) begin
         osc_tick_i <= ~osc_tick_i;
      end
   end

   pwrc_core #(.MCD_CYCLES(MCD_N), .WDT_CYCLES(WDT_N), .RST_CYCLES(RST_N)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .instr_done_i(instr_done_i), .irq_i(irq_i), .rst_pin_n_i(rst_pin_n_i),
      .osc_tick_i(osc_tick_i), .ctl_o(ctl_o), .reset_addr_o(reset_addr_o));

   // ----------------------------------------------------------------
   // bus and sequencing tasks
   // ----------------------------------------------------------------
   // one classic cycle; request held until ack is sampled high
   // no limit of its own: a lost answer is ended by the hang guard
   task automatic wb_cycle(input logic [11:0] a, input logic w, input logic [3:0] s,
         input logic [7:0] wd, output logic [7:0] rdat);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= {24'h0, wd};
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rdat = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] wd);
      logic [7:0] dummy;
      wb_cycle(a, 1'b1, 4'hF, wd, dummy);
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] rdat);
      wb_cycle(a, 1'b0, 4'hF, 8'h00, rdat);
   endtask

   // one instruction completes; returns where the new mode is visible
   task automatic step_instr;
      @(posedge clk_i);
      instr_done_i <= 1'b1;
      @(posedge clk_i);
      instr_done_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // bounded wait for a control pattern, then compare it
   task automatic wait_ctl(input pwrc_ctl_t ex, input int lim, output int k);
      k = 0;
      while (ctl_o !== ex && k < lim) begin
         @(posedge clk_i);
         k++;
      end
      `TB_CHK("ctl_o", ex, ctl_o)
   endtask

   // reset cause comes from the model queue, not from the design
   task automatic chk_cause;
      int c;
      c = cause_q.pop_front();
      rd(A_STAT, q);
      `TB_CHK("status cause", 2'(c), q[5:4])
      `TB_CHK("status mode", 2'h0, q[1:0])
      rd(A_PCTL, q);
      model_flags = 0;
      `TB_CHK("power_control after reset", 8'(model_flags), q)
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(72));
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      `TB_CHK("ctl_o in reset", C_RSEQ, ctl_o)
      wait_ctl(C_RUN, RST_N + 4, n);
      `TB_CHK("reset length", 1'b1, n >= RST_N - 1)
      `TB_CHK("reset_addr_o", `PWRC_RESET_ADDR, reset_addr_o)
      rd(A_PCTL, q);
      `TB_CHK("power_control reset", `PWRC_POWER_CONTROL_RST, q)
      // random writes: selects read zero, flags stored
      repeat (6) begin
         d = 8'($urandom);
         wr(A_PCTL, d);
         model_flags = d & 8'h7C;
         rd(A_PCTL, q);
         `TB_CHK("power_control", 8'(model_flags), q)
      end
      wb_cycle(A_PCTL, 1'b1, 4'hE, 8'hFF, q);
      wr(A_NONE, 8'hFF);
      rd(A_NONE, q);
      `TB_CHK("unmapped read", 8'h00, q)
      rd(A_PCTL, q);
      `TB_CHK("power_control kept", 8'(model_flags), q)
      // idle entered, state kept, interrupt wakes
      wr(A_PCTL, 8'h55);
      model_flags = 8'h54;
      // the completing instruction stands for the two-byte follow-up
      step_instr();
      `TB_CHK("ctl_o idle", C_IDLE, ctl_o)
      rd(A_STAT, q);
      `TB_CHK("status idle", 3'h5, q[2:0])
      rd(A_PCTL, q);
      `TB_CHK("flags in idle", 8'(model_flags), q)
      irq_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      `TB_CHK("ctl_o wake", C_RUN, ctl_o)
      irq_i <= 1'b0;
      rd(A_STAT, q);
      `TB_CHK("status after wake", 3'h0, q[2:0])
      // both selects give stop; interrupt ignored; detector resets
      wr(A_SAFE, 8'h02);
      // no analog blocks are modelled, so none is left to shut down
      wr(A_PCTL, 8'h07);
      rd(A_STAT, q);
      `TB_CHK("status stop pending", 4'h8, q[3:0])
      step_instr();
      `TB_CHK("ctl_o stop", C_STOP, ctl_o)
      irq_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      `TB_CHK("ctl_o stop irq", C_STOP, ctl_o)
      irq_i <= 1'b0;
      cause_q.push_back(3);
      wait_ctl(C_RSEQ, MCD_N + 8, n);
      `TB_CHK("detector delay", 1'b1, n + 6 >= MCD_N - 6)
      wait_ctl(C_RUN, RST_N + 4, n);
      wr(A_SAFE, 8'h00);
      chk_cause();
      // watchdog keeps counting in idle; a kick restarts its interval
      wr(A_SAFE, 8'h01);
      repeat (40) @(posedge clk_i);
      wr(A_SAFE, 8'h05);
      rd(A_SAFE, q);
      `TB_CHK("safety", 8'h01, q)
      wr(A_PCTL, 8'h01);
      step_instr();
      `TB_CHK("ctl_o idle wdt", C_IDLE, ctl_o)
      cause_q.push_back(2);
      wait_ctl(C_RSEQ, WDT_N + 8, n);
      `TB_CHK("watchdog delay", 1'b1, n >= WDT_N - 16)
      wait_ctl(C_RUN, RST_N + 4, n);
      wr(A_SAFE, 8'h00);
      chk_cause();
      // external pin ends idle
      wr(A_PCTL, 8'h01);
      step_instr();
      rst_pin_n_i <= 1'b0;
      cause_q.push_back(1);
      wait_ctl(C_RSEQ, 6, n);
      rst_pin_n_i <= 1'b1;
      wait_ctl(C_RUN, RST_N + 8, n);
      `TB_CHK("reset_addr_o pin", `PWRC_RESET_ADDR, reset_addr_o)
      chk_cause();
      tally_and_finish();
   end

   // hang guard, well beyond the expected few hundred cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      tally_and_finish();
   end
endmodule

// >>> pwrc_pkg.sv
// Purpose: types shared by the power control block
// Assumes: nothing beyond the register header
// Notes: holds types only, numbers live in the header
package pwrc_pkg;

   // ----------------------------------------------------------------
   // operating modes of the core
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PWRC_RUN,
      PWRC_IDLE,
      PWRC_STOP,
      PWRC_RSEQ
   } pwrc_mode_t;

   // ----------------------------------------------------------------
   // software view of the power control register
   // ----------------------------------------------------------------
   typedef struct packed {
      logic baud_double_select;
      logic [4:0] general_flag;
      logic stop_select;
      logic idle_select;
   } pwrc_pctl_t;

   // clock and reset controls toward the core
   typedef struct packed {
      logic cpu_clk_en;
      logic periph_clk_en;
      logic osc_run;
      logic cpu_rst;
   } pwrc_ctl_t;

endpackage

// >>> pwrc_regs.svh
// Purpose: register map, field positions and timing counts of the power control block
// Assumes: included by bare name, definitions only
// Notes: register indices are word indices; byte address is four times the index
`ifndef PWRC_REGS_SVH
`define PWRC_REGS_SVH

// ----------------------------------------------------------------
// register indices and reset values
// ----------------------------------------------------------------
`define PWRC_IDX_POWER_CONTROL 10'h087
`define PWRC_IDX_STATUS 10'h090
`define PWRC_IDX_SAFETY 10'h091
`define PWRC_POWER_CONTROL_RST 8'h00
`define PWRC_SAFETY_RST 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PWRC_BIT_IDLE 0
`define PWRC_BIT_STOP 1
`define PWRC_FLAGS_LSB 2
`define PWRC_FLAGS_MSB 6
`define PWRC_BIT_WDT_EN 0
`define PWRC_BIT_MCD_EN 1
`define PWRC_BIT_WDT_KICK 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PWRC_CLK_PERIOD_NS 20
`define PWRC_MCD_TIMEOUT_US 100
`define PWRC_MCD_CYCLES ((`PWRC_MCD_TIMEOUT_US * 1000) / `PWRC_CLK_PERIOD_NS)
`define PWRC_WDT_CYCLES 65536
`define PWRC_RST_SEQ_CYCLES 16
`define PWRC_RESET_ADDR 16'h0000

`endif

// >>> pwrc_timeout.sv
// Purpose: timeout counter shared by the watchdog and missing clock detector
// Assumes: synchronous active-high reset on clk_i
// Notes: expire_o pulses once when CYCLES enabled cycles pass without clear
module pwrc_timeout #(
   parameter int CYCLES = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic clear_i,
   // result
   output logic expire_o
);
   localparam int W = $clog2(CYCLES + 1);

   logic [W-1:0] cnt_r;

   // refused at elaboration: a zero interval cannot be counted
   if (CYCLES < 1) begin
      $error("pwrc_timeout: CYCLES must be at least 1");
   end

   // count while running; clear and stop both restart the interval
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i || !run_i) begin
         cnt_r <= '0;
      end else if (cnt_r != W'(CYCLES)) begin
         cnt_r <= cnt_r + W'(1);
      end
   end

   // one pulse on reaching the terminal count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         expire_o <= 1'b0;
      end else begin
         expire_o <= run_i && !clear_i && (cnt_r == W'(CYCLES - 1));
      end
   end

endmodule
